// ---- dupc_core.sv ----
// Core: data registers, clear, soft reset, thermal latch and power-down control
`timescale 1ns/1ps
module dupc_core #(
    parameter bit          LOW_RES          = 1'b0,
    parameter int unsigned POR_DELAY        = dupc_pkg::POR_DELAY_CYCLES
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Decoded frame from the serial front end
    input  wire logic        frame_select_n,
    input  wire logic        frame_crc_mode,
    input  wire logic [5:0]  frame_bit_count,
    input  wire logic        data_write,
    input  wire logic [15:0] data_value,
    input  wire logic        software_clear_trigger,
    input  wire logic [3:0]  soft_reset_field,
    input  wire logic        alarm_clear_trigger,
    // Configuration bits
    input  wire logic        bipolar_range,
    input  wire logic        dac_power_down_bit,
    input  wire logic        device_power_down_bit,
    input  wire logic        reference_power_down_bit,
    input  wire logic        thermal_fault_pin_enable,
    // Temperature comparator
    input  wire logic        over_temperature,
    // Outputs
    output logic [15:0]      buffer_code,
    output logic [15:0]      active_code,
    output logic             amp_enable,
    output logic             output_clamp,
    output logic             reference_enable,
    output logic             thermal_alarm_flag,
    output logic             fault_n,
    output logic             por_busy,
    output logic             trigger_readback,
    output logic             update_strobe
);
    import dupc_pkg::*;

    localparam logic [POR_CNT_WIDTH-1:0] POR_LOAD = POR_CNT_WIDTH'(POR_DELAY);

    // Frame-select edge detection
    logic        sel_prev;
    logic        frame_end;
    logic        frame_valid;

    // Pending frame content captured while frame-select is low
    logic        pend_write;
    logic [15:0] pend_value;
    logic        pend_clear;
    logic        pend_reset;
    logic        pend_alarm_clr;

    // Data path state
    logic [15:0] next_buffer_code;
    logic [15:0] next_active_code;
    logic        next_update_strobe;
    logic        next_trigger_readback;

    // Power, alarm and reset state
    dupc_out_state_t             out_state;
    dupc_out_state_t             next_out_state;
    logic                        next_thermal_alarm_flag;
    logic                        next_fault_n;
    logic                        next_amp_enable;
    logic                        next_output_clamp;
    logic                        next_reference_enable;
    logic [POR_CNT_WIDTH-1:0]    por_count;
    logic [POR_CNT_WIDTH-1:0]    next_por_count;
    logic                        next_por_busy;
    logic                        next_pend_write;
    logic [15:0]                 next_pend_value;
    logic                        next_pend_clear;
    logic                        next_pend_reset;
    logic                        next_pend_alarm_clr;
    logic                        soft_reset;
    logic [15:0]                 clear_code;
    logic [15:0]                 code_mask;

    // Frame counts only with enough bits; extra bits are ignored upstream
    assign frame_end   = ~sel_prev & frame_select_n;
    assign frame_valid = frame_crc_mode ? (frame_bit_count >= 6'(FRAME_BITS_CRC))
                                        : (frame_bit_count >= 6'(FRAME_BITS));
    assign soft_reset  = frame_end & frame_valid & pend_reset;
    assign code_mask   = LOW_RES ? 16'h0FFF : 16'hFFFF;
    assign clear_code  = bipolar_range ? (LOW_RES ? CODE_MID_LOW_RES : CODE_MID)
                                       : CODE_ZERO;

    // Capture of commands during a frame
    always_comb begin
        next_pend_write     = pend_write;
        next_pend_value     = pend_value;
        next_pend_clear     = pend_clear;
        next_pend_reset     = pend_reset;
        next_pend_alarm_clr = pend_alarm_clr;
        if (frame_end || soft_reset) begin
            next_pend_write     = 1'b0;
            next_pend_clear     = 1'b0;
            next_pend_reset     = 1'b0;
            next_pend_alarm_clr = 1'b0;
        end else if (!frame_select_n && !por_busy) begin
            if (data_write) begin
                next_pend_write = 1'b1;
                next_pend_value = data_value & code_mask;
            end
            if (software_clear_trigger) begin
                next_pend_clear = 1'b1;
            end
            if (soft_reset_field == SOFT_RESET_KEY) begin
                next_pend_reset = 1'b1;
            end
            if (alarm_clear_trigger) begin
                next_pend_alarm_clr = 1'b1;
            end
        end
    end

    // Buffer and active data registers
    always_comb begin
        next_buffer_code      = buffer_code;
        next_active_code      = active_code;
        next_update_strobe    = 1'b0;
        next_trigger_readback = 1'b0;
        if (frame_end && frame_valid && !soft_reset) begin
            if (pend_clear) begin
                next_buffer_code   = clear_code;
                next_active_code   = clear_code;
                next_update_strobe = 1'b1;
            end else if (pend_write) begin
                // Accepted regardless of power state
                next_buffer_code   = pend_value;
                next_active_code   = pend_value;
                next_update_strobe = 1'b1;
            end
        end
        if (soft_reset) begin
            next_buffer_code = CODE_ZERO;
            next_active_code = CODE_ZERO;
        end
    end

    // Output stage power, thermal latch and fault pin
    always_comb begin
        next_out_state          = out_state;
        next_thermal_alarm_flag = thermal_alarm_flag;
        if (over_temperature) begin
            next_thermal_alarm_flag = 1'b1;
        end else if (frame_end && frame_valid && pend_alarm_clr && dac_power_down_bit) begin
            next_thermal_alarm_flag = 1'b0;
        end
        case (out_state)
            DUPC_OUT_ACTIVE: begin
                if (next_thermal_alarm_flag) begin
                    next_out_state = DUPC_OUT_SHUTDOWN;
                end else if (dac_power_down_bit || device_power_down_bit) begin
                    next_out_state = DUPC_OUT_CLAMPED;
                end
            end
            DUPC_OUT_CLAMPED: begin
                if (next_thermal_alarm_flag) begin
                    next_out_state = DUPC_OUT_SHUTDOWN;
                end else if (!dac_power_down_bit && !device_power_down_bit && !por_busy) begin
                    next_out_state = DUPC_OUT_ACTIVE;
                end
            end
            DUPC_OUT_SHUTDOWN: begin
                if (!next_thermal_alarm_flag) begin
                    next_out_state = DUPC_OUT_CLAMPED;
                end
            end
            default: begin
                next_out_state = DUPC_OUT_CLAMPED;
            end
        endcase
        if (soft_reset) begin
            next_out_state          = DUPC_OUT_CLAMPED;
            next_thermal_alarm_flag = over_temperature;
        end
        next_amp_enable       = (next_out_state == DUPC_OUT_ACTIVE);
        next_output_clamp     = (next_out_state != DUPC_OUT_ACTIVE);
        // Reference kept on through thermal shutdown
        next_reference_enable = !soft_reset && !reference_power_down_bit
                                && !device_power_down_bit && !por_busy;
        next_fault_n          = !(next_thermal_alarm_flag && thermal_fault_pin_enable);
    end

    // Reset delay counter, restarted by soft reset
    always_comb begin
        next_por_count = por_count;
        if (soft_reset) begin
            next_por_count = POR_LOAD;
        end else if (por_count != '0) begin
            next_por_count = por_count - POR_CNT_WIDTH'(1);
        end
        next_por_busy = (next_por_count != '0);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_prev           <= 1'b1;
            pend_write         <= 1'b0;
            pend_value         <= CODE_ZERO;
            pend_clear         <= 1'b0;
            pend_reset         <= 1'b0;
            pend_alarm_clr     <= 1'b0;
            buffer_code        <= CODE_ZERO;
            active_code        <= CODE_ZERO;
            update_strobe      <= 1'b0;
            trigger_readback   <= 1'b0;
            out_state          <= DUPC_OUT_CLAMPED;
            thermal_alarm_flag <= 1'b0;
            amp_enable         <= 1'b0;
            output_clamp       <= 1'b1;
            reference_enable   <= 1'b0;
            fault_n            <= 1'b1;
            por_count          <= POR_LOAD;
            por_busy           <= 1'b1;
        end else if (clk_en) begin
            sel_prev           <= frame_select_n;
            pend_write         <= next_pend_write;
            pend_value         <= next_pend_value;
            pend_clear         <= next_pend_clear;
            pend_reset         <= next_pend_reset;
            pend_alarm_clr     <= next_pend_alarm_clr;
            buffer_code        <= next_buffer_code;
            active_code        <= next_active_code;
            update_strobe      <= next_update_strobe;
            trigger_readback   <= next_trigger_readback;
            out_state          <= next_out_state;
            thermal_alarm_flag <= next_thermal_alarm_flag;
            amp_enable         <= next_amp_enable;
            output_clamp       <= next_output_clamp;
            reference_enable   <= next_reference_enable;
            fault_n            <= next_fault_n;
            por_count          <= next_por_count;
            por_busy           <= next_por_busy;
        end
    end
endmodule : dupc_core

// ---- dupc_pkg.sv ----
// Package: constants and types for the DAC update and power control block
package dupc_pkg;
    // Resolution variants
    localparam int unsigned CODE_WIDTH          = 16;
    localparam int unsigned CODE_WIDTH_LOW_RES  = 12;
    // Serial frame lengths in bits
    localparam int unsigned FRAME_BITS          = 24;
    localparam int unsigned FRAME_BITS_CRC      = 32;
    // Reset values
    localparam logic [15:0] CODE_ZERO           = 16'h0000;
    localparam logic [15:0] CODE_MID            = 16'h8000;
    localparam logic [15:0] CODE_MID_LOW_RES    = 16'h0800;
    localparam logic [3:0]  SOFT_RESET_KEY      = 4'hA;
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS       = 100;
    localparam int unsigned POR_DELAY_US        = 1000;
    localparam int unsigned POR_DELAY_CYCLES    = (POR_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned UPDATE_SPACING_NS   = 2400;
    localparam int unsigned UPDATE_SPACING_CYCLES =
        (UPDATE_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POR_CNT_WIDTH       = 16;
    // Power state of the output stage
    typedef enum logic [1:0] {
        DUPC_OUT_ACTIVE,
        DUPC_OUT_CLAMPED,
        DUPC_OUT_SHUTDOWN
    } dupc_out_state_t;
endpackage : dupc_pkg

// ---- dupc_props.sv ----
// Checker of port-level behaviour for the DAC update and power control core
`timescale 1ns/1ps
module dupc_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Configuration
    input wire logic        dac_power_down_bit,
    input wire logic        device_power_down_bit,
    // Outputs
    input wire logic [15:0] buffer_code,
    input wire logic [15:0] active_code,
    input wire logic        amp_enable,
    input wire logic        output_clamp,
    input wire logic        reference_enable,
    input wire logic        thermal_alarm_flag,
    input wire logic        fault_n,
    input wire logic        por_busy,
    input wire logic        trigger_readback,
    input wire logic        update_strobe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_strobe_one_cycle: assert property (update_strobe |=> !update_strobe)
        else $error("update strobe longer than one cycle");
    a_codes_match: assert property (update_strobe |-> active_code == buffer_code)
        else $error("active code differs from buffer code");
    a_code_held: assert property ($changed(active_code) |-> update_strobe || por_busy)
        else $error("active code changed without a load");
    a_clamp_amp: assert property (amp_enable |-> !output_clamp)
        else $error("output clamped while amplifier on");
    a_amp_cause: assert property (amp_enable |-> !$past(dac_power_down_bit) && !$past(device_power_down_bit))
        else $error("amplifier on while a power-down bit set");
    a_alarm_amp_off: assert property (thermal_alarm_flag |-> !amp_enable)
        else $error("amplifier on during thermal alarm");
    a_alarm_ref_kept: assert property ($rose(thermal_alarm_flag) && !por_busy && $past(reference_enable)
        |-> reference_enable)
        else $error("reference lost on thermal alarm");
    a_fault_cause: assert property (!fault_n |-> thermal_alarm_flag)
        else $error("fault pin low without alarm");
    a_alarm_latched: assert property ($fell(thermal_alarm_flag) && !por_busy |-> $past(dac_power_down_bit))
        else $error("alarm cleared while dac active");
    a_trigger_zero: assert property (trigger_readback == 1'b0)
        else $error("trigger field reads nonzero");
    a_busy_defaults: assert property (por_busy |-> active_code == 16'h0000 && !amp_enable)
        else $error("defaults not held during reset delay");
endmodule : dupc_props

bind dupc_core dupc_props u_props (.clk, .rst_n, .dac_power_down_bit, .device_power_down_bit, .buffer_code,
    .active_code, .amp_enable, .output_clamp, .reference_enable, .thermal_alarm_flag, .fault_n, .por_busy,
    .trigger_readback, .update_strobe);

// ---- dupc_host.sv ----
// Host model that opens and closes command frames
`timescale 1ns/1ps
module dupc_host (
    // Clock
    input wire logic   clk,
    // Frame signals
    output logic       frame_select_n,
    output logic       frame_crc_mode,
    output logic [5:0] frame_bit_count,
    output logic       data_write,
    output logic [15:0] data_value,
    output logic       software_clear_trigger,
    output logic [3:0] soft_reset_field,
    output logic       alarm_clear_trigger
);
    import dupc_pkg::*;
    initial begin
        frame_select_n = 1'b1;
        {frame_crc_mode, frame_bit_count, data_write, data_value} = '0;
        {software_clear_trigger, soft_reset_field, alarm_clear_trigger} = '0;
    end
    // Too few counted bits makes a short frame
    task automatic send(input logic wr, input logic [15:0] val, input logic clr, input logic [3:0] key,
                        input logic alm, input int bits, input logic crc);
        repeat (UPDATE_SPACING_CYCLES) @(posedge clk);
        frame_select_n <= 1'b0;
        frame_crc_mode <= crc;
        frame_bit_count <= 6'h00;
        data_write <= wr;
        data_value <= val;
        software_clear_trigger <= clr;
        soft_reset_field <= key;
        alarm_clear_trigger <= alm;
        repeat (bits) begin
            @(posedge clk);
            frame_bit_count <= frame_bit_count + 6'h01;
        end
        @(posedge clk);
        frame_select_n <= 1'b1;
        @(posedge clk);
        // Released data line shows the inverse, not a stale value
        data_value <= ~val;
        frame_bit_count <= 6'h00;
        {data_write, software_clear_trigger, soft_reset_field, alarm_clear_trigger} <= '0;
    endtask : send
endmodule : dupc_host

// ---- dac_update_power_control_tb.sv ----
// Self-checking bench for the DAC update and power control core
`timescale 1ns/1ps
module dac_update_power_control_tb;
    import dupc_pkg::*;
    localparam logic [15:0] ON = 16'h0001;
    logic        clk, rst_n, clk_en, bipolar_range, dac_power_down_bit, device_power_down_bit;
    logic        reference_power_down_bit, thermal_fault_pin_enable, over_temperature;
    logic        frame_select_n, frame_crc_mode, data_write, software_clear_trigger, alarm_clear_trigger;
    logic [5:0]  frame_bit_count;
    logic [3:0]  soft_reset_field;
    logic [15:0] data_value, buffer_code, active_code;
    logic        amp_enable, output_clamp, reference_enable, thermal_alarm_flag, fault_n, por_busy;
    logic        trigger_readback, update_strobe;
    int          mismatches, checked;

    dupc_core #(.LOW_RES(1'b0), .POR_DELAY(4)) DUT (.*);
    dupc_host host (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic results;
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wait_por;
        int n;
        n = 0;
        while (por_busy !== 1'b0 && n < 100) begin
            tick(1);
            n++;
        end
        chk("por_busy", CODE_ZERO, por_busy);
        if (n >= 100) results();
    endtask : wait_por

    task automatic t_write;
        host.send(1'b1, 16'h1234, 1'b0, 4'h0, 1'b0, 24, 1'b0);
        // Strobe stands only in the cycle after the closing edge
        #1;
        chk("active_code", 16'h1234, active_code);
        chk("buffer_code", 16'h1234, buffer_code);
        chk("update_strobe", ON, update_strobe);
        chk("amp_enable", CODE_ZERO, amp_enable);
        host.send(1'b1, 16'h5555, 1'b0, 4'h0, 1'b0, 23, 1'b0);
        host.send(1'b1, 16'h5555, 1'b0, 4'h0, 1'b0, 24, 1'b1);
        tick(2);
        chk("active_code", 16'h1234, active_code);
        host.send(1'b1, 16'hFFFF, 1'b0, 4'h0, 1'b0, 32, 1'b1);
        tick(1);
        chk("active_code", 16'hFFFF, active_code);
    endtask : t_write

    task automatic t_power;
        {dac_power_down_bit, device_power_down_bit, reference_power_down_bit} <= 3'b000;
        tick(3);
        chk("amp_enable", ON, amp_enable);
        chk("output_clamp", CODE_ZERO, output_clamp);
        chk("reference_enable", ON, reference_enable);
        @(posedge clk);
        dac_power_down_bit <= 1'b1;
        tick(3);
        chk("output_clamp", ON, output_clamp);
        chk("reference_enable", ON, reference_enable);
        chk("active_code", 16'hFFFF, active_code);
        @(posedge clk);
        {dac_power_down_bit, device_power_down_bit} <= 2'b01;
        tick(3);
        chk("amp_enable", CODE_ZERO, amp_enable);
        @(posedge clk);
        device_power_down_bit <= 1'b0;
        tick(3);
        chk("amp_enable", ON, amp_enable);
    endtask : t_power

    task automatic t_clear;
        for (int b = 0; b < 2; b++) begin
            bipolar_range <= b[0];
            host.send(1'b1, 16'h1111, 1'b1, 4'h0, 1'b0, 24, 1'b0);
            tick(1);
            chk("active_code", b[0] ? CODE_MID : CODE_ZERO, active_code);
            chk("buffer_code", b[0] ? CODE_MID : CODE_ZERO, buffer_code);
        end
    endtask : t_clear

    task automatic t_thermal;
        thermal_fault_pin_enable <= 1'b1;
        over_temperature <= 1'b1;
        tick(2);
        chk("amp_enable", CODE_ZERO, amp_enable);
        chk("reference_enable", ON, reference_enable);
        chk("fault_n", CODE_ZERO, fault_n);
        @(posedge clk);
        over_temperature <= 1'b0;
        host.send(1'b0, 16'h0000, 1'b0, 4'h0, 1'b1, 24, 1'b0);
        tick(2);
        chk("thermal_alarm_flag", ON, thermal_alarm_flag);
        dac_power_down_bit <= 1'b1;
        host.send(1'b0, 16'h0000, 1'b0, 4'h0, 1'b1, 24, 1'b0);
        tick(2);
        chk("thermal_alarm_flag", CODE_ZERO, thermal_alarm_flag);
        thermal_fault_pin_enable <= 1'b0;
        over_temperature <= 1'b1;
        tick(2);
        chk("fault_n", ON, fault_n);
        over_temperature <= 1'b0;
    endtask : t_thermal

    task automatic t_soft_reset;
        host.send(1'b0, 16'h0000, 1'b0, 4'h5, 1'b0, 24, 1'b0);
        tick(2);
        chk("active_code", CODE_MID, active_code);
        host.send(1'b0, 16'h0000, 1'b0, 4'hA, 1'b0, 24, 1'b0);
        tick(1);
        chk("active_code", CODE_ZERO, active_code);
        chk("por_busy", ON, por_busy);
        chk("output_clamp", ON, output_clamp);
        chk("trigger_readback", CODE_ZERO, trigger_readback);
        wait_por();
    endtask : t_soft_reset

    initial begin
        mismatches = 0;
        checked = 0;
        {rst_n, bipolar_range, thermal_fault_pin_enable, over_temperature} = '0;
        {clk_en, dac_power_down_bit, device_power_down_bit, reference_power_down_bit} = '1;
        tick(6);
        chk("amp_enable", CODE_ZERO, amp_enable);
        chk("reference_enable", CODE_ZERO, reference_enable);
        chk("fault_n", ON, fault_n);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_por();
        t_write();
        t_power();
        t_clear();
        t_thermal();
        t_soft_reset();
        results();
    end
endmodule : dac_update_power_control_tb
